// ### rtl/rfm_defines.vh
// Purpose: constants for the reference frequency offset monitor
// Assumes: 250 MHz system clock, offsets held in 0.01 ppm units
// Notes: byte registers, lower address holds the high byte
`ifndef RFM_DEFINES_VH
`define RFM_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define RFM_ADDR_CTRL 16'h0592
`define RFM_ADDR_DISQ_HI 16'h0593
`define RFM_ADDR_DISQ_LO 16'h0594
`define RFM_ADDR_QUAL_HI 16'h0595
`define RFM_ADDR_QUAL_LO 16'h0596
`define RFM_ADDR_WIN_HI 16'h0597
`define RFM_ADDR_WIN_LO 16'h0598
`define RFM_ADDR_JUMP 16'h0599

// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define RFM_RST_CTRL 1'h0
`define RFM_RST_DISQ 16'h32B4
`define RFM_RST_QUAL 16'h2724
`define RFM_RST_WIN 16'h0000
`define RFM_RST_JUMP 8'h28
`define RFM_CTRL_RES_BIT 0

// ----------------------------------------------------------------
// scaling in 0.01 ppm units; window and ten-second average in seconds
// ----------------------------------------------------------------
`define RFM_FINE_STEP 20'h00001
`define RFM_COARSE_STEP 20'h0000A
`define RFM_JUMP_STEP 32'h0000000A
`define RFM_DEFAULT_WIN 12'h00A
`define RFM_MAX_WIN 12'h800
`define RFM_AVG10_SECS 12'h00A
`define RFM_AVG10_LAST 4'h9

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RFM_CLK_HZ 250000000
`define RFM_GATE_S 1
`define RFM_SEC_CYCLES (`RFM_CLK_HZ * `RFM_GATE_S)
`define RFM_NOM_COUNT 32'h00989680
`define RFM_UNITS_PER_COUNT 32'h0000000A
`define RFM_NUM_REFS 10
`define RFM_DIV_STEPS 6'h20

`endif

// ### rtl/rfm_sdiv.v
// Purpose: serial signed-by-unsigned divider, one quotient bit a cycle
// Assumes: divisor nonzero; start only while not busy
// Notes: quotient truncates toward zero
`timescale 1ns/1ns
`include "rfm_defines.vh"

module rfm_sdiv (
  input wire clock_in,
  input wire arst_n_in,
  input wire start_in,
  input wire signed [31:0] num_in,
  input wire [11:0] den_in,
  output reg done_out,
  output reg signed [31:0] quo_out
);

  reg [32:0] rem_r;
  reg [31:0] q_r;
  reg [11:0] den_r;
  reg neg_r;
  reg [5:0] cnt_r;
  wire [32:0] rem_sh;
  wire take;

  assign rem_sh = {rem_r[31:0], q_r[31]};
  assign take = (rem_sh >= {21'h000000, den_r});

  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rem_r <= 33'h000000000;
      q_r <= 32'h00000000;
      den_r <= 12'h001;
      neg_r <= 1'b0;
      cnt_r <= 6'h00;
      done_out <= 1'b0;
      quo_out <= 32'sh00000000;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        rem_r <= 33'h000000000;
        q_r <= num_in[31] ? (32'h00000000 - num_in) : num_in;
        neg_r <= num_in[31];
        den_r <= den_in;
        cnt_r <= `RFM_DIV_STEPS;
      end else if (cnt_r != 6'h00) begin
        rem_r <= take ? (rem_sh - {21'h000000, den_r}) : rem_sh;
        q_r <= {q_r[30:0], take};
        cnt_r <= cnt_r - 6'h01;
        if (cnt_r == 6'h01) begin
          done_out <= 1'b1;
          quo_out <= neg_r ? (32'sh00000000 - $signed({q_r[30:0], take}))
                           : $signed({q_r[30:0], take});
        end
      end
    end
  end

endmodule

// ### rtl/rfm_monitor.v
// Purpose: frequency offset monitor with averaging filter and hysteresis
// Assumes: reference pins asynchronous, well below half the system clock
// Notes: one fail flag per reference, refreshed once per second
`timescale 1ns/1ns
`include "rfm_defines.vh"

module rfm_monitor #(
  parameter SEC_CYCLES = `RFM_SEC_CYCLES,
  parameter [31:0] NOM_COUNT = `RFM_NOM_COUNT
) (
  input wire clock_in,
  input wire arst_n_in,
  input wire [`RFM_NUM_REFS-1:0] ref_clk_in,
  input wire [15:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  output wire [`RFM_NUM_REFS-1:0] freq_fail_out
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  reg res_r;
  reg [15:0] disq_r;
  reg [15:0] qual_r;
  reg [15:0] win_r;
  reg [7:0] jump_r;
  reg [7:0] rd_nxt;

  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      res_r <= `RFM_RST_CTRL;
      disq_r <= `RFM_RST_DISQ;
      qual_r <= `RFM_RST_QUAL;
      win_r <= `RFM_RST_WIN;
      jump_r <= `RFM_RST_JUMP;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `RFM_ADDR_CTRL: res_r <= reg_wdata_in[`RFM_CTRL_RES_BIT];
        `RFM_ADDR_DISQ_HI: disq_r[15:8] <= reg_wdata_in;
        `RFM_ADDR_DISQ_LO: disq_r[7:0] <= reg_wdata_in;
        `RFM_ADDR_QUAL_HI: qual_r[15:8] <= reg_wdata_in;
        `RFM_ADDR_QUAL_LO: qual_r[7:0] <= reg_wdata_in;
        `RFM_ADDR_WIN_HI: win_r[15:8] <= reg_wdata_in;
        `RFM_ADDR_WIN_LO: win_r[7:0] <= reg_wdata_in;
        `RFM_ADDR_JUMP: jump_r <= reg_wdata_in;
        default: res_r <= res_r;
      endcase
    end
  end

  always @* begin
    case (reg_addr_in)
      `RFM_ADDR_CTRL: rd_nxt = {7'h00, res_r};
      `RFM_ADDR_DISQ_HI: rd_nxt = disq_r[15:8];
      `RFM_ADDR_DISQ_LO: rd_nxt = disq_r[7:0];
      `RFM_ADDR_QUAL_HI: rd_nxt = qual_r[15:8];
      `RFM_ADDR_QUAL_LO: rd_nxt = qual_r[7:0];
      `RFM_ADDR_WIN_HI: rd_nxt = win_r[15:8];
      `RFM_ADDR_WIN_LO: rd_nxt = win_r[7:0];
      `RFM_ADDR_JUMP: rd_nxt = jump_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // derived settings
  // ----------------------------------------------------------------
  wire [11:0] win_secs;
  wire [19:0] qual_units;
  wire [19:0] disq_units;
  wire [31:0] jump_units;

  // whole seconds, clamped at the top
  // zero falls back to ten seconds
  assign win_secs = (win_r == 16'h0000) ? `RFM_DEFAULT_WIN :
                    (win_r > {4'h0, `RFM_MAX_WIN}) ? `RFM_MAX_WIN :
                    win_r[11:0];
  assign qual_units = {4'h0, qual_r} *
                      (res_r ? `RFM_COARSE_STEP : `RFM_FINE_STEP);
  assign disq_units = {4'h0, disq_r} *
                      (res_r ? `RFM_COARSE_STEP : `RFM_FINE_STEP);
  assign jump_units = {24'h000000, jump_r} * `RFM_JUMP_STEP;

  // ----------------------------------------------------------------
  // one-second gate, shared by all references
  // ----------------------------------------------------------------
  reg [31:0] sec_cnt_r;
  reg sec_tick_r;

  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sec_cnt_r <= 32'h00000000;
      sec_tick_r <= 1'b0;
    end else if (sec_cnt_r == SEC_CYCLES - 1) begin
      sec_cnt_r <= 32'h00000000;
      sec_tick_r <= 1'b1;
    end else begin
      sec_cnt_r <= sec_cnt_r + 32'h00000001;
      sec_tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // per-reference measurement, filter and decision
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_AVG10 = 2'h1;
  localparam [1:0] ST_FILT = 2'h2;

  genvar g;
  generate
    for (g = 0; g < `RFM_NUM_REFS; g = g + 1) begin : refs
      reg [2:0] sync_r;
      reg [31:0] edges_r;
      reg signed [31:0] samp_r;
      reg signed [31:0] filt_r;
      reg signed [31:0] avg10_r;
      reg avg10_ok_r;
      reg signed [31:0] acc10_r;
      reg [3:0] blk_r;
      reg [1:0] st_r;
      reg fail_r;
      reg div_go_r;
      reg signed [31:0] div_num_r;
      reg [11:0] div_den_r;
      wire div_done;
      wire signed [31:0] div_quo;
      wire edge_seen;
      wire [31:0] edges_now;
      wire signed [32:0] diff;
      wire [63:0] prod;
      wire signed [31:0] samp_now;
      wire signed [31:0] filt_new;
      wire signed [31:0] jump_gap;
      wire [31:0] gap_mag;
      wire signed [31:0] filt_fin;
      wire [31:0] off_mag;

      // rising edge taken after the two-stage synchroniser
      assign edge_seen = sync_r[1] & ~sync_r[2];
      assign edges_now = edges_r + {31'h00000000, edge_seen};
      assign diff = $signed({1'b0, edges_now}) - $signed({1'b0, NOM_COUNT});
      assign prod = {{32{diff[31]}}, diff[31:0]} *
                    {32'h00000000, `RFM_UNITS_PER_COUNT};
      assign samp_now = prod[31:0];
      assign filt_new = filt_r + div_quo;
      assign jump_gap = filt_new - avg10_r;
      assign gap_mag = jump_gap[31] ? (32'h00000000 - jump_gap) : jump_gap;
      // reload with ten-second average on a large jump
      assign filt_fin = (jump_r != 8'h00 && avg10_ok_r &&
                         gap_mag > jump_units) ? avg10_r : filt_new;
      assign off_mag = filt_fin[31] ? (32'h00000000 - filt_fin) : filt_fin;
      assign freq_fail_out[g] = fail_r;

      always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          sync_r <= 3'h0;
          edges_r <= 32'h00000000;
        end else begin
          sync_r <= {sync_r[1:0], ref_clk_in[g]};
          edges_r <= sec_tick_r ? 32'h00000000 : edges_now;
        end
      end

      always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          samp_r <= 32'sh00000000;
          filt_r <= 32'sh00000000;
          avg10_r <= 32'sh00000000;
          avg10_ok_r <= 1'b0;
          acc10_r <= 32'sh00000000;
          blk_r <= 4'h0;
          st_r <= ST_IDLE;
          fail_r <= 1'b0;
          div_go_r <= 1'b0;
          div_num_r <= 32'sh00000000;
          div_den_r <= 12'h001;
        end else begin
          div_go_r <= 1'b0;
          case (st_r)
            ST_IDLE: begin
              if (sec_tick_r) begin
                samp_r <= samp_now;
                div_go_r <= 1'b1;
                if (blk_r == `RFM_AVG10_LAST) begin
                  blk_r <= 4'h0;
                  acc10_r <= 32'sh00000000;
                  div_num_r <= acc10_r + samp_now;
                  div_den_r <= `RFM_AVG10_SECS;
                  st_r <= ST_AVG10;
                end else begin
                  blk_r <= blk_r + 4'h1;
                  acc10_r <= acc10_r + samp_now;
                  div_num_r <= samp_now - filt_r;
                  div_den_r <= win_secs;
                  st_r <= ST_FILT;
                end
              end
            end
            ST_AVG10: begin
              if (div_done) begin
                avg10_r <= div_quo;
                avg10_ok_r <= 1'b1;
                div_go_r <= 1'b1;
                div_num_r <= samp_r - filt_r;
                div_den_r <= win_secs;
                st_r <= ST_FILT;
              end
            end
            ST_FILT: begin
              if (div_done) begin
                filt_r <= filt_fin;
                st_r <= ST_IDLE;
                if (off_mag > {12'h000, disq_units}) begin
                  fail_r <= 1'b1;
                end else if (off_mag < {12'h000, qual_units}) begin
                  fail_r <= 1'b0;
                end
              end
            end
            default: st_r <= ST_IDLE;
          endcase
        end
      end

      rfm_sdiv u_div (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .start_in(div_go_r),
        .num_in(div_num_r),
        .den_in(div_den_r),
        .done_out(div_done),
        .quo_out(div_quo)
      );
    end
  endgenerate

endmodule

// ### test/rfm_ref_model.sv
// Purpose: reference clock sources for the offset monitor
// Assumes: 1000-cycle gate of 4 us, 100 nominal edges per gate
// Notes: ref 0 runs fast, ref 1 slow, the rest nominal
`timescale 1ns/1ns

module rfm_ref_model (
  output logic [9:0] ref_clk_out
);
  genvar i;
  // ----------
  // sources
  // ----------
  for (i = 0; i < 10; i = i + 1) begin : g_src
    localparam int HALF = (i == 0) ? 16 : (i == 1) ? 25 : 20;
    initial begin
      ref_clk_out[i] = 1'h0;
      // edges of refs 0 and 2-9 fall on odd ns and miss every system clock edge; ref 1 (half period 25) also lands on clock edges
      #1;
      forever #HALF ref_clk_out[i] = ~ref_clk_out[i];
    end
  end
endmodule

// ### test/rfm_monitor_properties.sv
// Purpose: port checks for the offset monitor
// Assumes: SEC_CYCLES equals the bound instance value
// Notes: shadow bytes follow register writes
`timescale 1ns/1ns
`include "rfm_defines.vh"

module rfm_monitor_properties #(
  parameter SEC_CYCLES = 1000
) (
  input wire clock_in,
  input wire arst_n_in,
  input wire [15:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire [9:0] freq_fail_out
);
  reg [15:0] qual_r;
  reg [15:0] win_r;
  reg [7:0] jump_r;
  reg res_r;
  reg [31:0] age_r;
  wire odd = reg_addr_in[0];
  wire [7:0] qual_b = odd ? qual_r[15:8] : qual_r[7:0];
  wire [7:0] win_b = odd ? win_r[15:8] : win_r[7:0];
  wire at_qual = reg_addr_in == `RFM_ADDR_QUAL_HI ||
    reg_addr_in == `RFM_ADDR_QUAL_LO;
  wire at_win = reg_addr_in == `RFM_ADDR_WIN_HI ||
    reg_addr_in == `RFM_ADDR_WIN_LO;

  // ----------
  // shadow registers
  // ----------
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      qual_r <= 16'h2724;
      win_r <= 16'h0000;
      jump_r <= 8'h28;
      res_r <= 1'h0;
      age_r <= 32'h00000000;
    end else begin
      if (age_r < SEC_CYCLES) begin
        age_r <= age_r + 32'h00000001;
      end
      if (reg_wr_in) begin
        case (reg_addr_in)
          `RFM_ADDR_CTRL: res_r <= reg_wdata_in[0];
          `RFM_ADDR_QUAL_HI: qual_r[15:8] <= reg_wdata_in;
          `RFM_ADDR_QUAL_LO: qual_r[7:0] <= reg_wdata_in;
          `RFM_ADDR_WIN_HI: win_r[15:8] <= reg_wdata_in;
          `RFM_ADDR_WIN_LO: win_r[7:0] <= reg_wdata_in;
          `RFM_ADDR_JUMP: jump_r <= reg_wdata_in;
          default: ;
        endcase
      end
    end
  end

  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);

  // reads see the value held before a same-cycle write
  qual_read_a: assert property (
    reg_rd_in && at_qual |=> reg_rdata_out == $past(qual_b))
    else $error("qualify byte read back wrong");
  // the raw setting is stored, clamping only shapes the filter
  win_read_a: assert property (
    reg_rd_in && at_win |=> reg_rdata_out == $past(win_b))
    else $error("window byte read back wrong");
  jump_read_a: assert property (
    reg_rd_in && reg_addr_in == `RFM_ADDR_JUMP
    |=> reg_rdata_out == $past(jump_r))
    else $error("jump limit read back wrong");
  ctrl_read_a: assert property (
    reg_rd_in && reg_addr_in == `RFM_ADDR_CTRL
    |=> reg_rdata_out == {7'h00, $past(res_r)})
    else $error("scale bit read back wrong");
  read_hold_a: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  early_flag_a: assert property (
    age_r < SEC_CYCLES |-> freq_fail_out == 10'h000)
    else $error("fail flag before first gate");
  flag0_hold_a: assert property (
    $changed(freq_fail_out[0]) |=> $stable(freq_fail_out[0]) [*8])
    else $error("fail flag 0 toggled twice");
  flag1_hold_a: assert property (
    $changed(freq_fail_out[1]) |=> $stable(freq_fail_out[1]) [*8])
    else $error("fail flag 1 toggled twice");

  cover property ($rose(freq_fail_out[0]));
  cover property ($fell(freq_fail_out[0]));
  cover property (reg_rd_in && at_win);
endmodule

bind rfm_monitor rfm_monitor_properties #(.SEC_CYCLES(SEC_CYCLES)) u_props (
  .clock_in(clock_in), .arst_n_in(arst_n_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .freq_fail_out(freq_fail_out));

// ### test/test_reference_freq_offset_monitor.sv
// Purpose: register and flag tests of the offset monitor
// Assumes: gate shortened to 1000 cycles, 100 nominal edges
// Notes: each flag test starts from reset for a clean filter
`timescale 1ns/1ns
`include "rfm_defines.vh"

module test_reference_freq_offset_monitor;
  localparam int SEC = 1000;
  logic clock_in = 1'h0;
  logic arst_n_in = 1'h0;
  logic [15:0] reg_addr_in = 16'h0000;
  logic reg_wr_in = 1'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_rd_in = 1'h0;
  wire [9:0] ref_clk;
  wire [7:0] reg_rdata_out;
  wire [9:0] freq_fail_out;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  int ticks = 0;

  always #2 clock_in = ~clock_in;

  rfm_ref_model partner (.ref_clk_out(ref_clk));
  rfm_monitor #(.SEC_CYCLES(SEC), .NOM_COUNT(32'h00000064)) dut (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .ref_clk_in(ref_clk),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .freq_fail_out(freq_fail_out));

  // ----------
  // tasks
  // ----------
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'h1;
    @(negedge clock_in);
    reg_wr_in = 1'h0;
  endtask

  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    wr(a, d[15:8]);
    wr(a + 16'h0001, d[7:0]);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clock_in);
    reg_addr_in = a;
    reg_rd_in = 1'h1;
    @(negedge clock_in);
    reg_rd_in = 1'h0;
    chk($sformatf("byte %h", a), {8'h00, exp}, {8'h00, reg_rdata_out});
  endtask

  task automatic restart();
    @(negedge clock_in);
    arst_n_in = 1'h0;
    repeat (8) @(negedge clock_in);
    arst_n_in = 1'h1;
  endtask

  task automatic setup(input logic [15:0] w, input logic [7:0] j,
                       input logic [15:0] dq, input logic [15:0] q);
    restart();
    wr16(`RFM_ADDR_WIN_HI, w);
    wr(`RFM_ADDR_JUMP, j);
    wr16(`RFM_ADDR_DISQ_HI, dq);
    wr16(`RFM_ADDR_QUAL_HI, q);
  endtask

  // flags settle within 100 cycles of the k-th gate tick
  task automatic after_gate(input int k, input logic [9:0] exp);
    while (cyc < k * SEC + 100) @(negedge clock_in);
    chk("fail flags", {6'h00, exp}, {6'h00, freq_fail_out});
  endtask

  always @(posedge clock_in) begin
    cyc <= arst_n_in ? cyc + 1 : 0;
    ticks <= ticks + 1;
    if (ticks == 40000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------
  // tests
  // ----------
  initial begin
    restart();
    rd(`RFM_ADDR_QUAL_HI, 8'h27);
    rd(`RFM_ADDR_QUAL_LO, 8'h24);
    rd(`RFM_ADDR_WIN_HI, 8'h00);
    rd(`RFM_ADDR_WIN_LO, 8'h00);
    rd(`RFM_ADDR_DISQ_HI, 8'h32);
    rd(`RFM_ADDR_DISQ_LO, 8'hB4);
    rd(`RFM_ADDR_JUMP, 8'h28);
    rd(16'h059A, 8'h00);
    wr(`RFM_ADDR_CTRL, 8'hFF);
    rd(`RFM_ADDR_CTRL, 8'h01);
    wr16(`RFM_ADDR_WIN_HI, 16'h0800);
    rd(`RFM_ADDR_WIN_HI, 8'h08);
    wr(`RFM_ADDR_JUMP, 8'hFF);
    rd(`RFM_ADDR_JUMP, 8'hFF);
    $display("test registers done");
    // one-second window, jump limit written as zero so the reload stays off
    setup(16'h0001, 8'h00, 16'h0064, 16'h0032);
    after_gate(1, 10'h003);
    wr16(`RFM_ADDR_DISQ_HI, 16'h012C);
    after_gate(2, 10'h003);
    wr16(`RFM_ADDR_QUAL_HI, 16'h0104);
    after_gate(3, 10'h000);
    wr(`RFM_ADDR_CTRL, 8'h01);
    wr16(`RFM_ADDR_DISQ_HI, 16'h0014);
    wr16(`RFM_ADDR_QUAL_HI, 16'h0013);
    after_gate(4, 10'h001);
    $display("test thresholds done");
    setup(16'h0000, 8'h01, 16'h00C8, 16'h0032);
    after_gate(1, 10'h000);
    after_gate(10, 10'h001);
    $display("test jump reload done");
    setup(16'h0000, 8'h00, 16'h00C8, 16'h0032);
    after_gate(10, 10'h000);
    $display("test jump off done");
    wrap_up();
  end
endmodule
